// File: qet_decode.sv
// Purpose: Quadrature decoder for synchronised phase inputs
// Assumes: Inputs already synchronised to clk
// Notes:   One tick per valid phase-state change
`timescale 1ns/100ps
`default_nettype none
module qet_decode
(
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire logic          pha,
   input  wire logic          phb,
   output var qet_pkg::qet_tick_t tick_o
);
   logic [1:0] prev_r;
   wire  [1:0] cur     = {pha, phb};
   wire        changed = (cur != prev_r);
   wire        legal   = (cur[1] ^ prev_r[1]) ^ (cur[0] ^ prev_r[0]);
   // A leading B: new A differs from old B
   wire        fwd     = cur[1] ^ prev_r[0];

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         prev_r <= 2'h0;
      else
         prev_r <= cur;
   end

   always_comb
   begin
      tick_o.tick = changed & legal;
      tick_o.dir  = fwd ? qet_pkg::QET_DIR_FWD : qet_pkg::QET_DIR_REV;
   end
endmodule
`default_nettype wire

// File: qet_enc_model.sv
// Purpose: Two-phase incremental encoder stand-in
// Assumes: Step requests one cycle long, spaced apart
// Notes:   Phase A leads phase B on a forward step
`timescale 1ns/100ps
`default_nettype none
module qet_enc_model
(
   input  wire logic clk,
   input  wire logic fwd,
   input  wire logic rev,
   output logic      pha,
   output logic      phb
);
   logic [1:0] pos_r = 2'h0;
   // One phase changes per step
   always @(posedge clk)
      pos_r <= pos_r + {rev, fwd | rev};
   assign pha = pos_r[0] ^ pos_r[1];
   assign phb = pos_r[1];
endmodule
`default_nettype wire

// File: qet_pkg.sv
// Purpose: Shared constants and types for the quadrature encoder trigger
// Assumes: One clock domain, 100 MHz
// Notes:   Counter widths follow the 0..32767 setting range
package qet_pkg;
   localparam int CNT_W = 15;
   localparam logic [CNT_W-1:0] CNT_ZERO      = 15'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX_LIMIT = 15'h7FFF;
   localparam logic [CNT_W-1:0] CNT_ONE       = 15'h0001;
   localparam logic [1:0] SEL_LINE1 = 2'h0;
   localparam logic [1:0] SEL_LINE2 = 2'h1;
   localparam logic [1:0] SEL_LINE3 = 2'h2;
   localparam logic [1:0] SEL_PHA_RST = 2'h0;
   localparam logic [1:0] SEL_PHB_RST = 2'h1;

   typedef enum logic [0:0] {
      QET_CNT_FOLLOW = 1'b0,
      QET_CNT_IGNORE = 1'b1
   } qet_cnt_mode_t;

   typedef enum logic [0:0] {
      QET_OUT_ANY = 1'b0,
      QET_OUT_FWD = 1'b1
   } qet_out_mode_t;

   typedef enum logic [0:0] {
      QET_DIR_FWD = 1'b0,
      QET_DIR_REV = 1'b1
   } qet_dir_t;

   typedef struct packed {
      logic     tick;
      qet_dir_t dir;
   } qet_tick_t;
endpackage

// File: qet_top.sv
// Purpose: Quadrature shaft-encoder trigger for line or frame start
// Assumes: Encoder lines asynchronous; control ports steady between commands
// Notes:   Outputs registered; trigger is one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Each phase selectable from input lines 1-3
// - Direction from phase order; swap inverts
// - Follow mode: forward up, reverse down
// - Ignore mode: every tick counts up
// - Tick count readable, not writable
// - Tick maximum programmable 0 to 32767
// - Increment at maximum wraps to zero
// - Decrement at zero wraps to maximum
// - Tick reset command clears count
// - Output mode: any direction or forward only
// - Reverse maximum programmable 0 to 32767
// - Reverse reset clears count, direction forward
// - Trigger pulse usable for line/frame start
// - Reverse ticks raise reverse count to maximum
// - Forward ticks lower nonzero reverse count
// - Forward only: trigger forward ticks when idle
// - Any direction: trigger all ticks when idle
module qet_top
(
   input  wire logic                        CLK,
   input  wire logic                        RST_B,
   input  wire logic [2:0]                  IN_LINE,
   input  wire logic [1:0]                  PHA_SEL,
   input  wire logic [1:0]                  PHB_SEL,
   input  wire qet_pkg::qet_cnt_mode_t      CNT_MODE,
   input  wire qet_pkg::qet_out_mode_t      OUT_MODE,
   input  wire logic [qet_pkg::CNT_W-1:0]   CNT_MAX,
   input  wire logic [qet_pkg::CNT_W-1:0]   REV_MAX,
   input  wire logic                        CNT_RESET,
   input  wire logic                        REV_RESET,
   output logic [qet_pkg::CNT_W-1:0]        TICK_COUNT,
   output logic [qet_pkg::CNT_W-1:0]        REV_COUNT,
   output logic                             CONV_DIR,
   output logic                             TRIG_OUT
);
   logic [1:0] rst_sync_r;
   logic       rst_b;
   wire  [2:0] line_sync;
   logic       pha_r;
   logic       phb_r;
   logic [qet_pkg::CNT_W-1:0] cnt_r;
   logic [qet_pkg::CNT_W-1:0] cnt_nxt;
   logic [qet_pkg::CNT_W-1:0] rev_r;
   logic [qet_pkg::CNT_W-1:0] rev_nxt;
   qet_pkg::qet_dir_t         dir_r;
   qet_pkg::qet_dir_t         dir_nxt;
   logic                      trig_r;
   logic                      trig_nxt;
   qet_pkg::qet_tick_t        tk;

   // Reset asserts at once and releases after two edges
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_b = rst_sync_r[1];

   // Two-flop synchroniser per camera input line
   for (genvar gi = 0; gi < $bits(IN_LINE); gi++)
   begin : g_line
      logic s1_r;
      logic s2_r;

      always_ff @(posedge CLK or negedge rst_b)
      begin
         if (!rst_b)
         begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
         end
         else
         begin
            s1_r <= IN_LINE[gi];
            s2_r <= s1_r;
         end
      end

      assign line_sync[gi] = s2_r;
   end

   // Line routing; unused code picks line 3
   wire pha_on1 = (PHA_SEL == qet_pkg::SEL_LINE1);
   wire pha_on2 = (PHA_SEL == qet_pkg::SEL_LINE2);
   wire phb_on1 = (PHB_SEL == qet_pkg::SEL_LINE1);
   wire phb_on2 = (PHB_SEL == qet_pkg::SEL_LINE2);
   wire pha_mux = pha_on1 ? line_sync[0] : pha_on2 ? line_sync[1] : line_sync[2];
   wire phb_mux = phb_on1 ? line_sync[0] : phb_on2 ? line_sync[1] : line_sync[2];

   // Routed phases registered once before decode
   always_ff @(posedge CLK or negedge rst_b)
   begin
      if (!rst_b)
         pha_r <= 1'b0;
      else
         pha_r <= pha_mux;
   end

   always_ff @(posedge CLK or negedge rst_b)
   begin
      if (!rst_b)
         phb_r <= 1'b0;
      else
         phb_r <= phb_mux;
   end

   // Decoder compares each new phase pair with the last
   qet_decode u_dec
   (
      .clk    (CLK),
      .rst_b  (rst_b),
      .pha    (pha_r),
      .phb    (phb_r),
      .tick_o (tk)
   );

   // Tick classification and counter enables
   wire is_fwd  = (tk.dir == qet_pkg::QET_DIR_FWD);
   wire cnt_up  = tk.tick & (is_fwd | (CNT_MODE == qet_pkg::QET_CNT_IGNORE));
   wire cnt_dn  = tk.tick & ~is_fwd & (CNT_MODE == qet_pkg::QET_CNT_FOLLOW);
   wire rev_inc = tk.tick & ~is_fwd & (rev_r < REV_MAX);
   wire rev_dec = tk.tick & is_fwd & (rev_r != qet_pkg::CNT_ZERO);
   wire rev_busy = rev_inc | rev_dec;
   wire trig_ok = tk.tick & ~rev_busy &
                  (is_fwd | (OUT_MODE == qet_pkg::QET_OUT_ANY));

   // Wrap tests; >= lets a lowered maximum still wrap
   wire cnt_top = (cnt_r >= CNT_MAX);
   wire cnt_bot = (cnt_r == qet_pkg::CNT_ZERO);
   wire [qet_pkg::CNT_W-1:0] cnt_plus  = cnt_r + qet_pkg::CNT_ONE;
   wire [qet_pkg::CNT_W-1:0] cnt_minus = cnt_r - qet_pkg::CNT_ONE;
   wire [qet_pkg::CNT_W-1:0] rev_plus  = rev_r + qet_pkg::CNT_ONE;
   wire [qet_pkg::CNT_W-1:0] rev_minus = rev_r - qet_pkg::CNT_ONE;

   // Reset commands win over a tick in the same cycle
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (CNT_RESET)
         cnt_nxt = qet_pkg::CNT_ZERO;
      else if (cnt_up)
         cnt_nxt = cnt_top ? qet_pkg::CNT_ZERO : cnt_plus;
      else if (cnt_dn)
         cnt_nxt = cnt_bot ? CNT_MAX : cnt_minus;
   end

   // Reverse counter saturates at its maximum
   always_comb
   begin
      rev_nxt = rev_r;
      if (REV_RESET)
         rev_nxt = qet_pkg::CNT_ZERO;
      else if (rev_inc)
         rev_nxt = rev_plus;
      else if (rev_dec)
         rev_nxt = rev_minus;
   end

   // Reverse reset forces the stored direction forward
   always_comb
   begin
      dir_nxt = dir_r;
      if (REV_RESET)
         dir_nxt = qet_pkg::QET_DIR_FWD;
      else if (tk.tick)
         dir_nxt = tk.dir;
   end

   // Reverse reset also blocks the trigger in its cycle
   assign trig_nxt = trig_ok & ~REV_RESET;

   // State registers; every output is one of them
   always_ff @(posedge CLK or negedge rst_b)
   begin
      if (!rst_b)
         cnt_r <= qet_pkg::CNT_ZERO;
      else
         cnt_r <= cnt_nxt;
   end

   always_ff @(posedge CLK or negedge rst_b)
   begin
      if (!rst_b)
         rev_r <= qet_pkg::CNT_ZERO;
      else
         rev_r <= rev_nxt;
   end

   // Stored conveyor direction
   always_ff @(posedge CLK or negedge rst_b)
   begin
      if (!rst_b)
         dir_r <= qet_pkg::QET_DIR_FWD;
      else
         dir_r <= dir_nxt;
   end

   // One-cycle trigger pulse
   always_ff @(posedge CLK or negedge rst_b)
   begin
      if (!rst_b)
         trig_r <= 1'b0;
      else
         trig_r <= trig_nxt;
   end

   // Count ports are read-only copies; no write path exists
   assign TICK_COUNT = cnt_r;
   assign REV_COUNT  = rev_r;
   assign CONV_DIR   = dir_r;
   assign TRIG_OUT   = trig_r;
endmodule
`default_nettype wire

// File: qet_top_assertions.sv
// Purpose: Port checks for qet_top
// Assumes: Maximum settings steady while ticks run
// Notes:   Bound to every qet_top
`timescale 1ns/100ps
`default_nettype none
module qet_top_assertions
(
   input wire logic                      CLK,
   input wire logic                      RST_B,
   input wire qet_pkg::qet_cnt_mode_t    CNT_MODE,
   input wire logic [qet_pkg::CNT_W-1:0] CNT_MAX,
   input wire logic [qet_pkg::CNT_W-1:0] REV_MAX,
   input wire logic                      CNT_RESET,
   input wire logic                      REV_RESET,
   input wire logic [qet_pkg::CNT_W-1:0] TICK_COUNT,
   input wire logic [qet_pkg::CNT_W-1:0] REV_COUNT,
   input wire logic                      CONV_DIR,
   input wire logic                      TRIG_OUT
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   sequence s_moved;
      !$stable(TICK_COUNT) && !$past(CNT_RESET);
   endsequence
   a_cnt_clear: assert property (CNT_RESET |=> TICK_COUNT == 0)
      else $error("count not cleared");
   a_rev_clear: assert property (REV_RESET |=> REV_COUNT == 0 && !CONV_DIR)
      else $error("reverse state not cleared");
   a_cnt_bound: assert property (!$stable(TICK_COUNT) |-> TICK_COUNT <= CNT_MAX)
      else $error("count above maximum");
   a_cnt_step: assert property (s_moved |-> TICK_COUNT == $past(TICK_COUNT) + 15'h1
      || TICK_COUNT == $past(TICK_COUNT) - 15'h1 || TICK_COUNT == 0 || TICK_COUNT == CNT_MAX)
      else $error("count jumped");
   a_ignore_up: assert property (s_moved |-> CNT_MODE == qet_pkg::QET_CNT_FOLLOW
      || TICK_COUNT == $past(TICK_COUNT) + 15'h1 || TICK_COUNT == 0)
      else $error("count fell in ignore mode");
   a_rev_cap: assert property (!$stable(REV_COUNT) |-> REV_COUNT <= REV_MAX)
      else $error("reverse count above maximum");
   a_rev_quiet: assert property (!$stable(REV_COUNT) && !$past(REV_RESET) |-> !TRIG_OUT)
      else $error("trigger while reverse count moved");
   a_trig_tick: assert property (TRIG_OUT && CNT_MAX != 0 && !$past(CNT_RESET)
      |-> !$stable(TICK_COUNT))
      else $error("trigger without tick");
endmodule
bind qet_top qet_top_assertions i_chk
(
   .CLK(CLK), .RST_B(RST_B), .CNT_MODE(CNT_MODE), .CNT_MAX(CNT_MAX), .REV_MAX(REV_MAX),
   .CNT_RESET(CNT_RESET), .REV_RESET(REV_RESET), .TICK_COUNT(TICK_COUNT),
   .REV_COUNT(REV_COUNT), .CONV_DIR(CONV_DIR), .TRIG_OUT(TRIG_OUT)
);
`default_nettype wire

// File: qet_top_tb.sv
// Purpose: Self-checking bench for qet_top
// Assumes: Encoder model on lines 1 to 3
// Notes:   Small reference model predicts counts
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module qet_top_tb;
   logic                      CLK, RST_B, fwd, rev, pha, phb, crst, rrst, trig, conv, sw;
   logic [1:0]                asel, bsel;
   logic [qet_pkg::CNT_W-1:0] cmax, rmax, cnt, rcnt, ec, er;
   qet_pkg::qet_cnt_mode_t    cm;
   qet_pkg::qet_out_mode_t    om;
   int                        bad_count, checks, trigs;
   qet_enc_model i_enc (.clk(CLK), .fwd(fwd), .rev(rev), .pha(pha), .phb(phb));
   qet_top i_dut
   (
      .CLK(CLK), .RST_B(RST_B), .IN_LINE({phb, phb, pha}), .PHA_SEL(asel), .PHB_SEL(bsel),
      .CNT_MODE(cm), .OUT_MODE(om), .CNT_MAX(cmax), .REV_MAX(rmax), .CNT_RESET(crst),
      .REV_RESET(rrst), .TICK_COUNT(cnt), .REV_COUNT(rcnt), .CONV_DIR(conv), .TRIG_OUT(trig)
   );
   initial
   begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   always @(posedge CLK)
      if (trig === 1'b1)
         trigs++;
   task automatic print_verdict;
      if (bad_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Sensed direction d: 1 is reverse; sw means phases swapped
   task automatic tick(input logic d);
      int   t;
      logic ch;
      t = trigs;
      ch = d ? (er < rmax) : (er != 0);
      if (cm == qet_pkg::QET_CNT_IGNORE || !d)
         ec = (ec >= cmax) ? 15'h0000 : ec + 15'h0001;
      else
         ec = (ec == 0) ? cmax : ec - 15'h0001;
      if (ch)
         er = d ? er + 15'h0001 : er - 15'h0001;
      {fwd, rev} = {!(d ^ sw), d ^ sw};
      @(posedge CLK) #1 {fwd, rev} = 2'h0;
      repeat (7) @(posedge CLK);
      #1 `CHK("counts", {ec, er}, {cnt, rcnt})
      `CHK("triggers", t + (!ch && (om == qet_pkg::QET_OUT_ANY || !d)), trigs)
      `CHK("direction", d, conv)
   endtask
   initial
   begin
      #100000;
      bad_count++;
      print_verdict;
   end
   initial
   begin
      {RST_B, fwd, rev, crst, rrst, sw, asel, rmax, ec, er} = '0;
      bsel = qet_pkg::SEL_LINE2;
      cmax = 15'h0005;
      cm = qet_pkg::QET_CNT_FOLLOW;
      om = qet_pkg::QET_OUT_ANY;
      repeat (12) @(posedge CLK);
      #1 RST_B = 1'b1;
      repeat (4) @(posedge CLK);
      #1 `CHK("reset", 31'h0, {cnt, rcnt, conv})
      repeat (8) tick(1'b0);
      repeat (4) tick(1'b1);
      crst = 1'b1;
      @(posedge CLK) #1 crst = 1'b0;
      @(posedge CLK) #1 `CHK("tick clear", 15'h0, cnt)
      ec = 15'h0;
      {sw, asel, bsel} = {1'b1, qet_pkg::SEL_LINE3, qet_pkg::SEL_LINE1};
      repeat (2) tick(1'b1);
      cm = qet_pkg::QET_CNT_IGNORE;
      repeat (2) tick(1'b1);
      cm = qet_pkg::QET_CNT_FOLLOW;
      om = qet_pkg::QET_OUT_FWD;
      rmax = 15'h0002;
      repeat (3) tick(1'b1);
      repeat (3) tick(1'b0);
      om = qet_pkg::QET_OUT_ANY;
      tick(1'b1);
      rrst = 1'b1;
      @(posedge CLK) #1 rrst = 1'b0;
      @(posedge CLK) #1 `CHK("reverse clear", 16'h0, {rcnt, conv})
      {ec, er, cmax} = {15'h0000, 15'h0000, 15'h7FFF};
      crst = 1'b1;
      @(posedge CLK) #1 crst = 1'b0;
      tick(1'b1);
      tick(1'b0);
      print_verdict;
   end
endmodule
`default_nettype wire
